// [design/sac_pkg.sv]
package sac_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] ADDR_RESULT = 8'h00_c2;
  localparam logic [7:0] ADDR_CONTROL = 8'h00_c3;
  localparam logic [7:0] RESULT_RESET = 8'h00_00;
  localparam logic [7:0] CONTROL_RESET = 8'h00_00;
  // Control fields; bits 7..3 have no function
  localparam int CTL_REQUEST_BIT = 0;
  localparam int CTL_CHANNEL_BIT = 1;
  localparam int CTL_AUTO_BIT = 2;
  localparam logic [4:0] CTL_RESERVED_READ = 5'h0_0;

  // ----------------------------------------
  // Converter shape
  // ----------------------------------------
  localparam int CODE_WIDTH = 8;
  localparam logic [7:0] TRIAL_MSB_ONLY = 8'h00_80;
  localparam logic [7:0] TRIAL_CLEAR = 8'h00_00;
  localparam logic [2:0] TRIAL_TOP_BIT = 3'h7;
  localparam int RANGE_MV = 2000;
  localparam int STEP_MV = 8;

  // ----------------------------------------
  // Timing at 125 MHz
  // ----------------------------------------
  localparam int CLOCK_KHZ = 125000;
  localparam int AUTO_PERIOD_MS = 30;
  localparam int AUTO_PERIOD_CYCLES = AUTO_PERIOD_MS * CLOCK_KHZ;
  localparam int AUTO_COUNT_WIDTH = 22;
  localparam int SETTLE_US = 10;
  localparam int SETTLE_CYCLES = (SETTLE_US * CLOCK_KHZ + 999) / 1000;
  localparam int SETTLE_COUNT_WIDTH = 12;
  localparam int MAX_CONVERT_MS = 50;
endpackage

// [design/sac_sar_if.sv]
`timescale 1ns/1ps
interface sac_sar_if;
  import sac_pkg::*;
  logic start;
  logic abort;
  logic done;
  logic [CODE_WIDTH-1:0] trial;

  modport ctl (output start, output abort, input done, input trial);
  modport eng (input start, input abort, output done, output trial);
endinterface

// [design/sac_sar_engine.sv]
`timescale 1ns/1ps
module sac_sar_engine #(
  parameter int SETTLE = sac_pkg::SETTLE_CYCLES
) (
  input wire logic sys_clk, // System clock
  input wire logic rst_b, // Asynchronous reset, active low
  input wire logic comp_raw, // Comparator: generated voltage above input
  sac_sar_if.eng sar // Start, abort, done and trial code
);
  import sac_pkg::*;

  typedef enum logic [0:0] {SAC_IDLE, SAC_WAIT} sac_state_t;

  sac_state_t state;
  sac_state_t next_state;
  logic [2:0] comp_sync;
  logic comp_level;
  logic next_comp_level;
  logic [2:0] bit_idx;
  logic [2:0] next_bit_idx;
  logic [SETTLE_COUNT_WIDTH-1:0] wait_cnt;
  logic [SETTLE_COUNT_WIDTH-1:0] next_wait_cnt;
  logic [CODE_WIDTH-1:0] next_trial;
  logic next_done;

  // ----------------------------------------
  // Comparator synchroniser
  // ----------------------------------------
  // Stage 0 feeds only stage 1; the level moves once stages 1 and 2 agree
  always_comb begin
    next_comp_level = comp_level;
    if (comp_sync[1] == comp_sync[2]) begin
      next_comp_level = comp_sync[2];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      comp_sync <= 3'h0;
      comp_level <= 1'b0;
    end else begin
      comp_sync <= {comp_sync[1:0], comp_raw};
      comp_level <= next_comp_level;
    end
  end

  // ----------------------------------------
  // Successive approximation sequence
  // ----------------------------------------
  // Settle time covers the analog source plus the synchroniser delay
  always_comb begin
    next_state = state;
    next_bit_idx = bit_idx;
    next_wait_cnt = wait_cnt;
    next_trial = sar.trial;
    next_done = 1'b0;
    case (state)
      SAC_IDLE: begin
        if (sar.start && !sar.abort) begin
          next_trial = TRIAL_MSB_ONLY;
          next_bit_idx = TRIAL_TOP_BIT;
          next_wait_cnt = '0;
          next_state = SAC_WAIT;
        end
      end
      SAC_WAIT: begin
        if (sar.abort) begin
          next_trial = TRIAL_CLEAR;
          next_state = SAC_IDLE;
        end else if (wait_cnt == SETTLE_COUNT_WIDTH'(SETTLE - 1)) begin
          // Trial too high: drop the bit just tried
          if (comp_level) begin
            next_trial[bit_idx] = 1'b0;
          end
          next_wait_cnt = '0;
          if (bit_idx == 3'h0) begin
            next_done = 1'b1;
            next_state = SAC_IDLE;
          end else begin
            next_bit_idx = bit_idx - 3'h1;
            next_trial[bit_idx - 3'h1] = 1'b1;
          end
        end else begin
          next_wait_cnt = wait_cnt + SETTLE_COUNT_WIDTH'(1);
        end
      end
      default: begin
        next_state = SAC_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= SAC_IDLE;
      bit_idx <= 3'h0;
      wait_cnt <= '0;
      sar.trial <= TRIAL_CLEAR;
      sar.done <= 1'b0;
    end else begin
      state <= next_state;
      bit_idx <= next_bit_idx;
      wait_cnt <= next_wait_cnt;
      sar.trial <= next_trial;
      sar.done <= next_done;
    end
  end
endmodule

// [design/sac_adc_control.sv]
`timescale 1ns/1ps
module sac_adc_control #(
  parameter int AUTO_CYCLES = sac_pkg::AUTO_PERIOD_CYCLES,
  parameter int SETTLE = sac_pkg::SETTLE_CYCLES
) (
  input wire logic sys_clk, // System clock, 125 MHz
  input wire logic rst_b, // Asynchronous reset, active low
  input wire logic system_on, // Chip in system-on mode
  input wire logic [7:0] sfr_addr, // Register address
  input wire logic sfr_wr, // Write strobe, one cycle
  input wire logic sfr_rd, // Read strobe, one cycle
  input wire logic [7:0] sfr_wdata, // Write data
  output logic [7:0] sfr_rdata, // Read data, valid cycle after strobe
  input wire logic comp_raw, // Comparator output from the analog side
  output logic [sac_pkg::CODE_WIDTH-1:0] trial_code, // Code to the voltage source
  output logic chan_sel, // Analog input select
  output logic conv_busy // Conversion in progress
);
  import sac_pkg::*;

  sac_sar_if sar ();

  logic request_bit;
  logic next_request_bit;
  logic chan_bit;
  logic next_chan_bit;
  logic auto_convert;
  logic next_auto_convert;
  logic [CODE_WIDTH-1:0] adc_result;
  logic [CODE_WIDTH-1:0] next_adc_result;
  logic [7:0] next_sfr_rdata;
  logic [AUTO_COUNT_WIDTH-1:0] auto_cnt;
  logic [AUTO_COUNT_WIDTH-1:0] next_auto_cnt;
  logic auto_pend;
  logic next_auto_pend;
  logic running;
  logic next_running;
  logic start;
  logic next_start;
  logic ctl_write;
  logic ctl_hit;
  logic res_hit;
  logic auto_due;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] reg_addr);
    hit = (addr == reg_addr);
  endfunction

  // Writes to the result address match nothing, so they fall away
  assign ctl_hit = hit(sfr_addr, ADDR_CONTROL);
  assign res_hit = hit(sfr_addr, ADDR_RESULT);
  assign ctl_write = sfr_wr && ctl_hit;

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  // A write in the done cycle wins, so a fresh request is never lost
  always_comb begin
    next_request_bit = request_bit;
    next_chan_bit = chan_bit;
    next_auto_convert = auto_convert;
    if (sar.done) begin
      next_request_bit = 1'b0;
    end
    if (ctl_write) begin
      next_request_bit = sfr_wdata[CTL_REQUEST_BIT];
      next_chan_bit = sfr_wdata[CTL_CHANNEL_BIT];
      next_auto_convert = sfr_wdata[CTL_AUTO_BIT];
    end
  end

  // Only three bits are stored; the reserved ones cost no flops
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      request_bit <= CONTROL_RESET[CTL_REQUEST_BIT];
      chan_bit <= CONTROL_RESET[CTL_CHANNEL_BIT];
      auto_convert <= CONTROL_RESET[CTL_AUTO_BIT];
    end else begin
      request_bit <= next_request_bit;
      chan_bit <= next_chan_bit;
      auto_convert <= next_auto_convert;
    end
  end

  // ----------------------------------------
  // Result register
  // ----------------------------------------
  // Loaded only on done, so an aborted run leaves the last good code
  always_comb begin
    next_adc_result = adc_result;
    if (sar.done) begin
      next_adc_result = sar.trial;
    end
  end

  // No write path reaches these flops
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      adc_result <= RESULT_RESET;
    end else begin
      adc_result <= next_adc_result;
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  // Read data registered; unmapped addresses answer zero
  always_comb begin
    next_sfr_rdata = sfr_rdata;
    if (sfr_rd) begin
      if (ctl_hit) begin
        next_sfr_rdata = {CTL_RESERVED_READ, auto_convert, chan_bit, request_bit};
      end else if (res_hit) begin
        next_sfr_rdata = adc_result;
      end else begin
        next_sfr_rdata = 8'h00_00;
      end
    end
  end

  // Held between reads, so software may pick it up late
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sfr_rdata <= 8'h00_00;
    end else begin
      sfr_rdata <= next_sfr_rdata;
    end
  end

  // ----------------------------------------
  // Periodic conversion timer
  // ----------------------------------------
  // Last count of the period
  assign auto_due = (auto_cnt == AUTO_COUNT_WIDTH'(AUTO_CYCLES - 1));

  // Counter clears whenever the auto bit or system-on is low
  always_comb begin
    next_auto_cnt = '0;
    if (auto_convert && system_on) begin
      next_auto_cnt = auto_due ? '0 : auto_cnt + AUTO_COUNT_WIDTH'(1);
    end
  end

  // Period counter flops
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      auto_cnt <= '0;
    end else begin
      auto_cnt <= next_auto_cnt;
    end
  end

  // A tick that lands while busy is held until the converter is free
  always_comb begin
    next_auto_pend = (auto_convert && system_on && auto_due) || (auto_pend && !start);
  end

  // Pending tick flop; a tick and a start in one cycle keep it set
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      auto_pend <= 1'b0;
    end else begin
      auto_pend <= next_auto_pend;
    end
  end

  // ----------------------------------------
  // Conversion launch
  // ----------------------------------------
  // Leaving system-on aborts; a held request restarts on return
  always_comb begin
    next_start = system_on && !running && !start && (request_bit || auto_pend);
    next_running = running;
    if (start) begin
      next_running = 1'b1;
    end
    if (sar.done || !system_on) begin
      next_running = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      start <= 1'b0;
      running <= 1'b0;
    end else begin
      start <= next_start;
      running <= next_running;
    end
  end

  // Outputs come straight from flops here or in the engine, except abort, which is system_on inverted
  assign sar.start = start;
  assign sar.abort = !system_on;
  // Eight settle periods of 10 us fit far inside the 50 ms budget
  assign conv_busy = running;
  assign trial_code = sar.trial;
  assign chan_sel = chan_bit;

  // Engine runs the eight compare steps against the analog side
  sac_sar_engine #(
    .SETTLE(SETTLE)
  ) u_engine (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .comp_raw(comp_raw),
    .sar(sar)
  );
endmodule

// [tb/sac_adc_control_props.sv]
`timescale 1ns/1ps
module sac_adc_control_props #(
  parameter int SETTLE = sac_pkg::SETTLE_CYCLES
) (
  input wire logic sys_clk, // Clock
  input wire logic rst_b, // Reset, active low
  input wire logic system_on, // Power mode
  input wire logic [7:0] sfr_addr, // Address
  input wire logic sfr_wr, // Write strobe
  input wire logic sfr_rd, // Read strobe
  input wire logic [7:0] sfr_wdata, // Write data
  input wire logic [7:0] sfr_rdata, // Read data
  input wire logic comp_raw, // Comparator
  input wire logic [sac_pkg::CODE_WIDTH-1:0] trial_code, // Trial code
  input wire logic chan_sel, // Channel
  input wire logic conv_busy // Busy
);
  import sac_pkg::*;
  // ----------------------------------------
  // Busy length counter
  // ----------------------------------------
  // Counted here because a repetition of thousands of cycles would stall the tools
  logic [15:0] busy_cnt;
  logic [15:0] next_busy_cnt;
  always_comb begin
    next_busy_cnt = conv_busy ? busy_cnt + 16'h0001 : 16'h0000;
  end
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_cnt <= 16'h0000;
    end else begin
      busy_cnt <= next_busy_cnt;
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  chk_start_code: assert property ($rose(conv_busy) |-> trial_code == TRIAL_MSB_ONLY)
    else $error("trial code not at midscale on start");
  chk_chan_follow: assert property (sfr_wr && sfr_addr == ADDR_CONTROL
    |=> chan_sel == $past(sfr_wdata[CTL_CHANNEL_BIT])) else $error("channel select not written");
  chk_reserved_zero: assert property (sfr_rd && sfr_addr == ADDR_CONTROL
    |=> sfr_rdata[7:3] == 5'h00) else $error("reserved control bits not zero");
  chk_unmapped_zero: assert property (sfr_rd && sfr_addr != ADDR_CONTROL
    && sfr_addr != ADDR_RESULT |=> sfr_rdata == 8'h0000) else $error("unmapped read not zero");
  chk_abort_idle: assert property (!system_on && conv_busy
    |-> ##[1:2] (!conv_busy && trial_code == 8'h0000)) else $error("conversion not aborted");
  chk_conv_length: assert property ($fell(conv_busy) && system_on && $past(system_on)
    |-> $past(busy_cnt) >= 8 * SETTLE - 2 && $past(busy_cnt) <= 8 * SETTLE + 2)
    else $error("conversion length wrong");
  chk_rdata_hold: assert property (!sfr_rd |=> $stable(sfr_rdata))
    else $error("read data changed without read");
  chk_trial_stands: assert property (!conv_busy && !$past(conv_busy)
    && !$past(conv_busy, 2) && !$past(conv_busy, 3) |-> $stable(trial_code))
    else $error("trial code moved while idle");
endmodule
bind sac_adc_control sac_adc_control_props #(.SETTLE(SETTLE)) u_sac_adc_control_props (
  .sys_clk(sys_clk), .rst_b(rst_b), .system_on(system_on), .sfr_addr(sfr_addr),
  .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
  .comp_raw(comp_raw), .trial_code(trial_code), .chan_sel(chan_sel), .conv_busy(conv_busy));

// [tb/sac_analog_model.sv]
`timescale 1ns/1ps
module sac_analog_model (
  input wire logic [7:0] trial_code, // Code to the voltage source
  input wire logic chan_sel, // Input select
  input wire logic [7:0] vin0, // Input zero level, 8 mV steps
  input wire logic [7:0] vin1, // Input one level, 8 mV steps
  output logic comp_raw // High while generated voltage is above input
);
  // Ideal comparator; no lag, so the design's own settle time is the only delay
  always_comb begin
    comp_raw = chan_sel ? (trial_code > vin1) : (trial_code > vin0);
  end
endmodule

// [tb/sac_adc_control_tb.sv]
`timescale 1ns/1ps
module sac_adc_control_tb;
  import sac_pkg::*;
  localparam int SETTLE = 8;
  localparam int AUTO = 200;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic system_on = 1'b1;
  logic [7:0] sfr_addr = 8'h0000;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_wdata = 8'h0000;
  logic [7:0] sfr_rdata;
  logic comp_raw;
  logic [CODE_WIDTH-1:0] trial_code;
  logic chan_sel;
  logic conv_busy;
  logic [7:0] vin0 = 8'h0000;
  logic [7:0] vin1 = 8'h0000;
  logic [7:0] rv;
  logic [7:0] exp_q[$];
  int failures = 0;
  int num_checks = 0;
  int seed = 94;
  int n;
  int k;
  // ----------------------------------------
  // Clock, parts and helpers
  // ----------------------------------------
  initial forever #4 sys_clk = ~sys_clk;
  sac_adc_control #(.AUTO_CYCLES(AUTO), .SETTLE(SETTLE)) u_sac_adc_control (
    .sys_clk(sys_clk), .rst_b(rst_b), .system_on(system_on), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .comp_raw(comp_raw), .trial_code(trial_code), .chan_sel(chan_sel), .conv_busy(conv_busy));
  sac_analog_model u_sac_analog_model (.trial_code(trial_code), .chan_sel(chan_sel),
    .vin0(vin0), .vin1(vin1), .comp_raw(comp_raw));
  // Bit-by-bit model of the approximation, kept apart from the design's logic
  function automatic logic [7:0] expect_code(input int v);
    int t;
    t = 0;
    for (int b = 7; b >= 0; b--) begin
      t = t | (1 << b);
      if (t > v) begin
        t = t & ~(1 << b);
      end
    end
    return t[7:0];
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge sys_clk);
    sfr_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge sys_clk);
    sfr_rd <= 1'b0;
    @(posedge sys_clk);
    d = sfr_rdata;
  endtask
  // Bounded wait; a stuck busy flag ends the wait and shows as a mismatch
  task automatic wait_done();
    n = 0;
    repeat (3) @(posedge sys_clk);
    while (conv_busy === 1'b1 && n < 40 * SETTLE) begin
      @(posedge sys_clk);
      n++;
    end
    check({7'h00, conv_busy}, 8'h0000);
  endtask
  task automatic results();
    if (failures == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    results();
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    rd(ADDR_RESULT, rv);
    check(rv, RESULT_RESET);
    rd(ADDR_CONTROL, rv);
    check(rv, CONTROL_RESET);
    wr(ADDR_CONTROL, 8'h00f8);
    rd(ADDR_CONTROL, rv);
    check(rv, 8'h0000);
    wr(ADDR_RESULT, 8'h0055);
    rd(ADDR_RESULT, rv);
    check(rv, RESULT_RESET);
    rd(8'h0010, rv);
    check(rv, 8'h0000);
    // Channel is changed only between conversions, as software must;
    // the first two runs put full scale on one input and zero on the other
    for (int i = 0; i < 8; i++) begin
      vin0 <= (i < 2) ? 8'h00ff : 8'($random(seed));
      vin1 <= (i < 2) ? 8'h0000 : 8'($random(seed));
      wr(ADDR_CONTROL, {6'h00, i[0], 1'b1});
      wait_done();
      check(8'(n), 8'(8 * SETTLE + 1));
      exp_q.push_back(expect_code(i[0] ? vin1 : vin0));
      rd(ADDR_CONTROL, rv);
      check(rv, {6'h00, i[0], 1'b0});
      rd(ADDR_RESULT, rv);
      check(rv, exp_q.pop_front());
    end
    // Power mode dropped mid conversion: abort, request kept, then resume
    wr(ADDR_CONTROL, 8'h0001);
    repeat (20) @(posedge sys_clk);
    system_on <= 1'b0;
    repeat (4) @(posedge sys_clk);
    check({conv_busy, 7'h00} | trial_code, 8'h0000);
    rd(ADDR_CONTROL, rv);
    check(rv, 8'h0001);
    system_on <= 1'b1;
    wait_done();
    rd(ADDR_RESULT, rv);
    check(rv, expect_code(vin0));
    // Automatic mode: a start per period without any request
    vin0 <= 8'h005a;
    wr(ADDR_CONTROL, 8'h0004);
    k = 0;
    repeat (3 * AUTO + AUTO / 2) begin
      @(posedge sys_clk);
      if (conv_busy === 1'b1 && u_sac_adc_control.conv_busy === 1'b1 && n == 0) begin
        k++;
      end
      n = (conv_busy === 1'b1) ? 1 : 0;
    end
    check({7'h00, k == 3}, 8'h0001);
    wr(ADDR_CONTROL, 8'h0000);
    wait_done();
    rd(ADDR_RESULT, rv);
    check(rv, expect_code(8'h5a));
    results();
  end
endmodule
